//--- rtl/sram_ctrl_pkg.sv
// Package for the pipelined synchronous SRAM control block.
// Assumes a single 125 MHz clock and no register bus.
package sram_ctrl_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 36;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int BURST_W = 2;
    // Timing: clock period in ns, sleep windows in clock periods
    localparam int CLOCK_PERIOD_NS = 8;
    localparam int SLEEP_ENTRY_IGNORE_DELAY_CYC = 2;
    localparam int SLEEP_EXIT_SAMPLE_DELAY_CYC = 2;
    localparam logic BURST_LINEAR = 1'h0;
    localparam logic BURST_INTERLEAVED = 1'h1;

    typedef struct packed {
        logic chip_select_b;
        logic chip_select_low_b;
        logic chip_select_high;
        logic advance_or_load;
        logic read_not_write;
        logic [ADDR_W-1:0] addr;
    } cmd_t;

    typedef struct packed {
        logic valid;
        logic is_write;
        logic [ADDR_W-1:0] addr;
    } stage_t;
endpackage

//--- rtl/sync_sram_sleep_and_cycle_ctrl.sv
// Control and array of a pipelined synchronous SRAM with sleep mode.
// Assumes the memory controller drives all inputs on sys_clk;
// only sleep_request is asynchronous.
`timescale 1ns/1ns
module sync_sram_sleep_and_cycle_ctrl
    import sram_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sleep_request,
    input wire logic clock_enable_b,
    input wire sram_ctrl_pkg::cmd_t cmd,
    input wire logic burst_order,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_out_en,
    output logic asleep
);
    import sram_ctrl_pkg::*;

    logic [DATA_W-1:0] mem [DEPTH];
    logic sleep_meta;
    logic sleep_sync;
    logic gate_inputs;
    logic selected;
    logic load;
    logic advance;
    stage_t stage1, next_stage1;
    stage_t stage2, next_stage2;
    logic [ADDR_W-1:0] base_addr, next_base_addr;
    logic [BURST_W-1:0] burst_cnt, next_burst_cnt;
    logic burst_is_write, next_burst_is_write;
    logic burst_live, next_burst_live;
    logic order_q, next_order_q;
    logic [ADDR_W-1:0] cur_addr;
    logic [BURST_W-1:0] low_bits;
    logic [BURST_W-1:0] burst_step;
    logic [DATA_W-1:0] next_data_out;
    logic next_data_out_en;
    logic [DATA_W-1:0] rd_word;

    // Pipeline timing, edge by edge
    // Edge L: a load is taken into stage1 with its address and direction
    // Edge L+1: stage1 moves to stage2; the next load may enter stage1
    // Edge L+2: a write stores data_in into the array at stage2's address
    // Edge L+2: a read registers the array word into data_out instead
    // A read's data_out_en is therefore high in the cycle after edge L+2
    //
    // Coherency
    // Writes and reads reach the array at the same pipeline depth
    // A read loaded right after a write meets the array one edge later
    // So the word it returns already holds the newest written data
    // A read loaded before a write returns the older word, as ordered
    // No bypass mux is needed, which keeps the read path short
    //
    // Stalls
    // A high clock_enable_b freezes both stages and the output register
    // The write of a frozen stage2 waits for the next enabled edge
    // The controller model freezes its write-data pipe the same way
    //
    // Sleep
    // The raw pin gates every input at once, with no clock edge needed
    // The synchronised copy keeps the gate up for two edges after release
    // Any operation in flight is dropped: the controller must drain first
    // On wake the pipe is empty, so outputs stay off until a new load
    //
    // Bursts
    // A load captures base address, direction and burst order together
    // Each advance steps a two-bit counter; only the low bits move
    // An advance with no live burst is treated as a plain idle cycle
    // Deselected loads end any burst, so later advances do nothing
    //
    // Limitations
    // The sleep pin also feeds the next-state logic unsynchronised
    // A release close to an edge may take one or two edges to settle
    // Both fall inside the allowed two-clock exit window
    //
    // Array
    // The array has no reset; reads of unwritten words return unknowns
    // Write enable is held off in reset, as stage2.valid resets low, so reset cannot corrupt words

    // Sleep request synchroniser; the asynchronous path below forces sleep at once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_meta <= 1'h0;
            sleep_sync <= 1'h0;
        end else begin
            sleep_meta <= sleep_request;
            sleep_sync <= sleep_meta;
        end
    end

    // Inputs ignored from the raw pin and for two edges after it falls
    assign gate_inputs = sleep_request | sleep_sync;
    assign asleep = sleep_request;

    // Selection and cycle decode
    assign selected = !cmd.chip_select_b && !cmd.chip_select_low_b && cmd.chip_select_high;
    assign load = !gate_inputs && !clock_enable_b && !cmd.advance_or_load;
    assign advance = !gate_inputs && !clock_enable_b && cmd.advance_or_load && burst_live;

    // Burst address generation: the next beat's address from the captured base
    // Only the low two bits move, so a burst stays in its aligned group of four
    always_comb begin
        burst_step = burst_cnt + 2'h1;
        low_bits = (order_q == BURST_INTERLEAVED) ? (base_addr[BURST_W-1:0] ^ burst_step)
                                                  : (base_addr[BURST_W-1:0] + burst_step);
        cur_addr = {base_addr[ADDR_W-1:BURST_W], low_bits};
    end

    // Pipeline next state: address stage then data stage
    always_comb begin
        next_stage1 = stage1;
        next_stage2 = stage2;
        next_base_addr = base_addr;
        next_burst_cnt = burst_cnt;
        next_burst_is_write = burst_is_write;
        next_burst_live = burst_live;
        next_order_q = order_q;
        if (gate_inputs) begin
            // Sleep flushes the pipe: operations in flight are dropped
            next_stage1 = '0;
            next_stage2 = '0;
            next_burst_live = 1'h0;
        end else if (!clock_enable_b) begin
            next_stage2 = stage1;
            if (load) begin
                next_stage1.valid = selected;
                next_stage1.is_write = !cmd.read_not_write;
                next_stage1.addr = cmd.addr;
                next_base_addr = cmd.addr;
                next_burst_cnt = '0;
                next_burst_is_write = !cmd.read_not_write;
                next_burst_live = selected;
                next_order_q = burst_order;
            end else if (advance) begin
                next_burst_cnt = burst_step;
                next_stage1.valid = 1'h1;
                next_stage1.is_write = burst_is_write;
                next_stage1.addr = cur_addr;
            end else begin
                next_stage1 = '0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            stage2 <= '0;
            base_addr <= '0;
            burst_cnt <= '0;
            burst_is_write <= 1'h0;
            burst_live <= 1'h0;
            order_q <= BURST_LINEAR;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            base_addr <= next_base_addr;
            burst_cnt <= next_burst_cnt;
            burst_is_write <= next_burst_is_write;
            burst_live <= next_burst_live;
            order_q <= next_order_q;
        end
    end

    // Array write: data arrives two edges after the address; never on a stall
    always_ff @(posedge sys_clk) begin
        if (!gate_inputs && !clock_enable_b && stage2.valid && stage2.is_write) begin
            mem[stage2.addr] <= data_in;
        end
    end

    // Read word; an earlier write has already landed at the same depth
    assign rd_word = mem[stage2.addr];

    // Registered output; the read's data stage sees the write in flight one step ahead
    always_comb begin
        next_data_out = data_out;
        next_data_out_en = data_out_en;
        if (gate_inputs) begin
            next_data_out_en = 1'h0;
        end else if (!clock_enable_b) begin
            next_data_out_en = stage2.valid && !stage2.is_write;
            if (stage2.valid && !stage2.is_write) begin
                next_data_out = rd_word;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= '0;
            data_out_en <= 1'h0;
        end else begin
            data_out <= next_data_out;
            data_out_en <= next_data_out_en;
        end
    end
endmodule

//--- bench/sram_ctrl_chk_asserts.sv
// Port checker for the SRAM control block.
// Assumes one clock and the asynchronous active-low reset.
`timescale 1ns/1ns
module sram_ctrl_chk
    import sram_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sleep_request,
    input wire logic clock_enable_b,
    input wire sram_ctrl_pkg::cmd_t cmd,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_out_en,
    input wire logic asleep
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Accepted load and full select
    wire logic ld = !clock_enable_b && !cmd.advance_or_load && !sleep_request;
    wire logic sel = !cmd.chip_select_b && !cmd.chip_select_low_b && cmd.chip_select_high;
    a_asleep_level: assert property (asleep == sleep_request)
        else $error("asleep level wrong");
    a_sleep_quiet: assert property (sleep_request [*2] |-> !data_out_en)
        else $error("driven in sleep");
    a_read_lat: assert property (!sleep_request [*4] ##0 (ld && sel && cmd.read_not_write)
        ##1 (!clock_enable_b && !sleep_request) [*2] |=> data_out_en) else $error("read lost");
    a_no_out: assert property (!sleep_request [*4] ##0 (ld && !(sel && cmd.read_not_write))
        ##1 (!clock_enable_b && !sleep_request) [*2] |=> !data_out_en) else $error("spurious read");
    a_stall_pause: assert property (clock_enable_b |=> !$rose(data_out_en))
        else $error("pipe moved in stall");
    a_exit_quiet: assert property ($fell(sleep_request) |-> !data_out_en [*3])
        else $error("output after exit");
    a_rise_awake: assert property ($rose(data_out_en) |-> !$past(sleep_request) && !$past(sleep_request, 2))
        else $error("read across sleep");
    a_data_hold: assert property (!data_out_en && !sleep_request && !$past(sleep_request) |-> $stable(data_out))
        else $error("data moved");
endmodule
bind sync_sram_sleep_and_cycle_ctrl sram_ctrl_chk chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .sleep_request(sleep_request), .clock_enable_b(clock_enable_b), .cmd(cmd), .data_out(data_out),
    .data_out_en(data_out_en), .asleep(asleep));

//--- bench/sram_ctrl_model.sv
// Memory controller model driving the command side.
// Assumes the bench calls op once per cycle.
`timescale 1ns/1ns
module sram_ctrl_model
    import sram_ctrl_pkg::*;
(
    input wire logic sys_clk,
    output sram_ctrl_pkg::cmd_t cmd,
    output logic clock_enable_b,
    output logic [DATA_W-1:0] data_in
);
    logic [DATA_W-1:0] d0 = 36'h0;
    logic [DATA_W-1:0] d1 = 36'hF;
    initial begin
        cmd = {3'h4, 2'h1, 17'h0};
        clock_enable_b = 1'h0;
        data_in = 36'h0;
    end
    // Write data trails its load by two edges, frozen by stalls
    always @(posedge sys_clk) begin
        if (!clock_enable_b) begin
            d1 <= d0;
            data_in <= d1;
        end
    end
    // Drives one command per edge; select bits come from the caller, bursts optional
    task automatic op(input logic [2:0] cs, input logic adv, input logic rnw, input logic st,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        cmd <= {cs, adv, rnw, a};
        clock_enable_b <= st;
        d0 <= d;
    endtask
endmodule

//--- bench/sync_sram_sleep_and_cycle_ctrl_tb.sv
// Self-checking bench: corner and random traffic.
// Assumes the checker is bound to the block.
`timescale 1ns/1ns
module sync_sram_sleep_and_cycle_ctrl_tb;
    import sram_ctrl_pkg::*;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic sleep_request = 1'h0;
    logic burst_order = 1'h0;
    logic clock_enable_b, data_out_en, asleep;
    cmd_t cmd;
    logic [DATA_W-1:0] data_in, data_out;
    int fails = 0, tests_run = 0, seed = 8916;
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] exp_q [$];
    initial forever #4 sys_clk = ~sys_clk;
    sram_ctrl_model ctl (.sys_clk(sys_clk), .cmd(cmd), .clock_enable_b(clock_enable_b), .data_in(data_in));
    sync_sram_sleep_and_cycle_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .sleep_request(sleep_request),
        .clock_enable_b(clock_enable_b), .cmd(cmd), .burst_order(burst_order), .data_in(data_in),
        .data_out(data_out), .data_out_en(data_out_en), .asleep(asleep));
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
        tests_run++;
        if (got !== want) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic results();
        $display("fails %0d tests_run %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Low two bits wrap: linear adds, interleaved XORs
    function automatic int baddr(input int a, input int o, input int i);
        baddr = (a & ~3) | (o ? ((a ^ i) & 3) : ((a + i) & 3));
    endfunction
    task automatic wr(input int a, input logic [DATA_W-1:0] d);
        ctl.op(3'h1, 1'h0, 1'h0, 1'h0, 17'(a), d);
        mem[a] = d;
    endtask
    task automatic rd(input int a);
        ctl.op(3'h1, 1'h0, 1'h1, 1'h0, 17'(a), 36'h0);
        exp_q.push_back(mem[a]);
    endtask
    task automatic idle(input int n);
        repeat (n) ctl.op(3'h4, 1'h0, 1'h1, 1'h0, 17'h0, 36'($random(seed)));
    endtask
    // Each driven read matches the oldest outstanding one
    always @(posedge sys_clk) begin
        if (data_out_en === 1'h1) begin
            if (exp_q.size() == 0) chk(data_out, ~data_out);
            else chk(data_out, exp_q.pop_front());
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        for (int i = 0; i < 12; i++) wr(i, 36'(i));
        // Only the full select mix may write or read
        for (int c = 0; c < 16; c++) begin
            ctl.op(3'(c), 1'h0, 1'(c / 8), 1'h0, 17'(c % 8), 36'h3C);
            if (c == 1) mem[1] = 36'h3C;
            if (c == 9) exp_q.push_back(mem[1]);
        end
        rd(3);
        ctl.op(3'h1, 1'h0, 1'h0, 1'h1, 17'h2, 36'hBAD);
        rd(2);
        for (int o = 0; o < 2; o++) begin
            burst_order <= 1'(o);
            for (int i = 0; i < 4; i++) begin
                ctl.op(3'h1, 1'(i > 0), 1'h0, 1'h0, 17'h9, 36'(o * 4 + i + 64));
                mem[baddr(9, o, i)] = 36'(o * 4 + i + 64);
            end
            for (int i = 8; i < 12; i++) rd(i);
        end
        for (int n = 0; n < 400; n++) begin
            if ($random(seed) & 1) rd($unsigned($random(seed)) % 12);
            else wr($unsigned($random(seed)) % 12, 36'({$random(seed), $random(seed)}));
        end
        idle(5);
        sleep_request <= 1'h1;
        for (int i = 0; i < 6; i++) ctl.op(3'h1, 1'h0, 1'(i % 2), 1'h0, 17'(i), 36'h5A);
        chk(36'(asleep), 36'h1);
        sleep_request <= 1'h0;
        idle(3);
        chk(36'(asleep), 36'h0);
        for (int i = 0; i < 6; i++) rd(i);
        idle(6);
        chk(36'(exp_q.size()), 36'h0);
        results();
    end
    initial begin
        #100000;
        fails++;
        results();
    end
endmodule
